// [rtl/rpf_port_regs.sv]
/*
 * Receive-port register bank: port select, remote alias decode with
 * remap and auto-acknowledge, per-port packet filter configuration and
 * strap-loaded link input mode.
 * Assumes an internal register port fed by the I2C target, an address
 * strobe raised before the address byte is acknowledged, and packet
 * descriptors on sys_clk.
 */
`timescale 1ns/1ps
module rpf_port_regs
    import rpf_pkg::*;
#(
    parameter int NUM_PORTS = NUM_PORTS_DEF
) (
    input  wire logic                        sys_clk,
    input  wire logic                        reset,
    input  wire logic                        ce,
    input  wire logic                        reg_wr_en,
    input  wire logic                        reg_rd_en,
    input  wire logic [7:0]                  reg_addr,
    input  wire logic [7:0]                  reg_wdata,
    output logic      [7:0]                  reg_rdata_ff,
    output logic                             reg_rvalid_ff,
    input  wire logic [1:0]                  strap_mode,
    input  wire logic                        i2c_addr_valid,
    input  wire logic [6:0]                  i2c_addr,
    input  wire logic                        i2c_read,
    output logic                             remote_hit_ff,
    output logic      [PSEL_W-1:0]           remote_port_ff,
    output logic      [6:0]                  remote_addr_ff,
    output logic                             auto_ack_ff,
    input  wire logic [NUM_PORTS-1:0]        pkt_valid,
    input  wire logic [NUM_PORTS-1:0]        pkt_frame_start,
    input  wire logic [NUM_PORTS-1:0][15:0]  pkt_frame_num,
    input  wire logic [NUM_PORTS-1:0]        pkt_ecc_err,
    input  wire logic [NUM_PORTS-1:0]        pkt_cksum_err,
    input  wire logic [NUM_PORTS-1:0]        pkt_len_err,
    input  wire logic [NUM_PORTS-1:0]        pkt_short_line,
    output logic      [NUM_PORTS-1:0]        pkt_pass_ff,
    output logic      [NUM_PORTS-1:0]        pkt_drop_ff
);

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    logic [PSEL_W-1:0] port_sel_ff;
    logic [7:0]        alias_ff  [NUM_PORTS];
    logic [6:0]        tid_ff    [NUM_PORTS];
    logic [7:0]        cfg_ff    [NUM_PORTS];
    logic [1:0]        mode_ff   [NUM_PORTS];
    logic [1:0]        strap_s1_ff;
    logic [1:0]        strap_s2_ff;
    logic [1:0]        strap_s3_ff;
    logic [1:0]        strap_cnt_ff;
    logic              strap_load_ff;

    rpf_filt_if #(.NUM_PORTS(NUM_PORTS)) fif (); 

    // ------------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------------
    wire wr_psel  = reg_wr_en && (reg_addr == ADDR_PORT_SEL);
    wire wr_alias = reg_wr_en && (reg_addr == ADDR_ALIAS);
    wire wr_cfg   = reg_wr_en && (reg_addr == ADDR_CFG);
    wire wr_tid   = reg_wr_en && (reg_addr == ADDR_TID);
    // A select past the last port reads zero rather than garbage
    wire sel_ok   = 32'(port_sel_ff) < NUM_PORTS;
    wire [7:0] rd_alias = sel_ok ? alias_ff[port_sel_ff] : 8'h00;
    wire [7:0] rd_tid   = sel_ok ? {1'b0, tid_ff[port_sel_ff]} : 8'h00;
    wire [7:0] rd_cfg   = sel_ok ? {cfg_ff[port_sel_ff][7:3], 1'b0,
                                    mode_ff[port_sel_ff]} : 8'h00;
    wire [7:0] rd_word  =
        (reg_addr == ADDR_PORT_SEL) ? {{(8-PSEL_W){1'b0}}, port_sel_ff} :
        (reg_addr == ADDR_ALIAS)    ? rd_alias :
        (reg_addr == ADDR_CFG)      ? rd_cfg :
        (reg_addr == ADDR_TID)      ? rd_tid : 8'h00;
    // Strap is trusted once the last two sync stages agree
    wire strap_take = strap_load_ff && (strap_cnt_ff == 2'(STRAP_FILL))
                      && (strap_s2_ff == strap_s3_ff);

    // Strap synchroniser; no reset so the pin level flows straight in
    always_ff @(posedge sys_clk) begin
        if (ce) begin
            strap_s1_ff <= strap_mode;
            strap_s2_ff <= strap_s1_ff;
            strap_s3_ff <= strap_s2_ff;
        end
    end

    // Strap capture window opens at reset release
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            strap_cnt_ff  <= 2'h0;
            strap_load_ff <= 1'b1;
        end else if (ce) begin
            if (strap_cnt_ff != 2'(STRAP_FILL))
                strap_cnt_ff <= strap_cnt_ff + 2'h1;
            if (strap_take)
                strap_load_ff <= 1'b0;
        end
    end

    // Per-port registers; a write in the strap cycle wins over the strap
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            port_sel_ff <= PSEL_RST;
            for (int p = 0; p < NUM_PORTS; p++) begin
                alias_ff[p] <= ALIAS_RST;
                tid_ff[p]   <= TID_RST;
                cfg_ff[p]   <= CFG_RST;
                mode_ff[p]  <= MODE_RST;
            end
        end else if (ce) begin
            if (wr_psel)
                port_sel_ff <= reg_wdata[PSEL_W-1:0];
            for (int p = 0; p < NUM_PORTS; p++) begin
                if (strap_take)
                    mode_ff[p] <= strap_s3_ff;
                if (port_sel_ff == PSEL_W'(p)) begin
                    if (wr_alias)
                        alias_ff[p] <= reg_wdata;
                    if (wr_tid)
                        tid_ff[p] <= reg_wdata[6:0];
                    if (wr_cfg) begin
                        cfg_ff[p]  <= {reg_wdata[7:3], 3'h0};
                        mode_ff[p] <= reg_wdata[1:0];
                    end
                end
            end
        end
    end

    // Read data is held until the next read
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            reg_rdata_ff  <= 8'h00;
            reg_rvalid_ff <= 1'b0;
        end else if (ce) begin
            reg_rvalid_ff <= reg_rd_en;
            if (reg_rd_en)
                reg_rdata_ff <= rd_word;
        end
    end

    // ------------------------------------------------------------------
    // Alias decode; lowest port wins if two ports share an alias
    // ------------------------------------------------------------------
    logic              hit_any;
    logic [PSEL_W-1:0] hit_port;

    always_comb begin
        hit_any  = 1'b0;
        hit_port = '0;
        for (int p = NUM_PORTS - 1; p >= 0; p--) begin
            if (alias_match(alias_ff[p], i2c_addr)) begin
                hit_any  = 1'b1;
                hit_port = PSEL_W'(p);
            end
        end
    end

    // One-cycle answer so the ACK slot of the address byte can use it
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            remote_hit_ff  <= 1'b0;
            remote_port_ff <= '0;
            remote_addr_ff <= 7'h00;
            auto_ack_ff    <= 1'b0;
        end else if (ce) begin
            remote_hit_ff <= i2c_addr_valid && hit_any;
            if (i2c_addr_valid && hit_any) begin
                remote_port_ff <= hit_port;
                remote_addr_ff <= tid_ff[hit_port];
            end
            auto_ack_ff <= i2c_addr_valid && hit_any && !i2c_read
                           && alias_ff[hit_port][ALIAS_AUTO_ACK];
        end
    end

    // ------------------------------------------------------------------
    // Packet filter
    // ------------------------------------------------------------------
    for (genvar p = 0; p < NUM_PORTS; p++) begin : g_bind
        assign fif.cfg[p]       = cfg_ff[p];
        assign fif.mode[p]      = mode_ff[p];
        assign fif.frame_num[p] = pkt_frame_num[p];
    end
    assign fif.pkt_valid  = pkt_valid;
    assign fif.pkt_fs     = pkt_frame_start;
    assign fif.ecc_err    = pkt_ecc_err;
    assign fif.cksum_err  = pkt_cksum_err;
    assign fif.len_err    = pkt_len_err;
    assign fif.short_line = pkt_short_line;
    assign pkt_pass_ff    = fif.pass;
    assign pkt_drop_ff    = fif.drop;

    rpf_pkt_filter #(.NUM_PORTS(NUM_PORTS)) u_filter (
        .sys_clk (sys_clk),
        .reset   (reset),
        .ce      (ce),
        .fif     (fif.filt)
    );

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    // Only a zero alias field could equal a zero address, so none may hit
    chk_alias_zero_blocks: assert property (
        ce && i2c_addr_valid && (i2c_addr == ALIAS_OFF) |=> !remote_hit_ff)
        else $error("zero alias produced a match");
    chk_alias_remap: assert property (
        ce && i2c_addr_valid && alias_match(alias_ff[0], i2c_addr)
        |=> remote_hit_ff && remote_port_ff == 2'h0
            && remote_addr_ff == $past(tid_ff[0]))
        else $error("alias not remapped to target id");
    chk_auto_ack_write: assert property (
        ce && i2c_addr_valid && alias_match(alias_ff[0], i2c_addr)
        |=> auto_ack_ff == ($past(alias_ff[0][ALIAS_AUTO_ACK])
                            && !$past(i2c_read)))
        else $error("auto acknowledge wrong");
    chk_write_routed: assert property (
        ce && wr_alias && port_sel_ff == 2'h1
        |=> alias_ff[1] == $past(reg_wdata)
            && alias_ff[0] == $past(alias_ff[0]))
        else $error("write reached wrong port");
    chk_strap_loads: assert property (
        ce && strap_take && !wr_cfg |=> mode_ff[0] == $past(strap_s3_ff))
        else $error("strap not loaded into mode");
    chk_cfg_reset: assert property (
        $fell(reset) |-> cfg_ff[0] == CFG_RST && strap_load_ff)
        else $error("port config reset value wrong");
    cov_remote_hit: cover property (ce && i2c_addr_valid ##1 remote_hit_ff);
    cov_auto_ack: cover property (auto_ack_ff);
    cov_strap: cover property (strap_take);

endmodule

// [rtl/rpf_pkg.sv]
/*
 * Shared constants for the receive-port alias and packet filter bank:
 * register offsets, field positions, reset values and mode encodings.
 * Assumes an 8-bit internal register port driven by the I2C target logic.
 */
package rpf_pkg;

    // ------------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------------
    localparam int NUM_PORTS_DEF = 4;
    localparam int PSEL_W        = 2;
    localparam int STRAP_FILL    = 3;   // Sync stages to fill after reset

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_PORT_SEL = 8'h4C;
    localparam logic [7:0] ADDR_ALIAS    = 8'h6C;
    localparam logic [7:0] ADDR_CFG      = 8'h6D;
    localparam logic [7:0] ADDR_TID      = 8'h5C;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [PSEL_W-1:0] PSEL_RST  = 2'h0;
    localparam logic [7:0]        ALIAS_RST = 8'h00;
    localparam logic [6:0]        TID_RST   = 7'h00;
    localparam logic [7:0]        CFG_RST   = 8'h78;
    localparam logic [1:0]        MODE_RST  = 2'h0;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int ALIAS_AUTO_ACK  = 0;
    localparam int CFG_WAIT_FIRST  = 7;
    localparam int CFG_WAIT_ANY    = 6;
    localparam int CFG_PASS_CKSUM  = 5;
    localparam int CFG_PASS_HDR    = 4;
    localparam int CFG_BIT3        = 3;   // Truncated line / length errors
    localparam int CFG_RSVD        = 2;

    // ------------------------------------------------------------------
    // Link input modes and frame numbers
    // ------------------------------------------------------------------
    localparam logic [1:0]  MODE_CSI      = 2'h0;
    localparam logic [1:0]  MODE_RAW12_LF = 2'h1;
    localparam logic [1:0]  MODE_RAW12_HF = 2'h2;
    localparam logic [1:0]  MODE_RAW10    = 2'h3;
    localparam logic [15:0] FRAME_NUM_ONE = 16'h0001;
    localparam logic [6:0]  ALIAS_OFF     = 7'h00;

    // Any mode other than CSI-2 is a raw parallel mode
    function automatic logic is_raw(input logic [1:0] mode);
        return mode != MODE_CSI;
    endfunction

    // Alias entry matches only when enabled (non-zero)
    function automatic logic alias_match(input logic [7:0] entry,
                                         input logic [6:0] addr);
        return (entry[7:1] != ALIAS_OFF) && (entry[7:1] == addr);
    endfunction

endpackage

// [rtl/rpf_filt_if.sv]
/*
 * Bundle between the register bank and the per-port packet filter.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
interface rpf_filt_if #(parameter int NUM_PORTS = 4);
    logic [7:0]           cfg        [NUM_PORTS];
    logic [1:0]           mode       [NUM_PORTS];
    logic [15:0]          frame_num  [NUM_PORTS];
    logic [NUM_PORTS-1:0] pkt_valid;
    logic [NUM_PORTS-1:0] pkt_fs;
    logic [NUM_PORTS-1:0] ecc_err;
    logic [NUM_PORTS-1:0] cksum_err;
    logic [NUM_PORTS-1:0] len_err;
    logic [NUM_PORTS-1:0] short_line;
    logic [NUM_PORTS-1:0] pass;
    logic [NUM_PORTS-1:0] drop;

    modport regs (output cfg, mode, frame_num, pkt_valid, pkt_fs, ecc_err,
                  cksum_err, len_err, short_line, input pass, drop);
    modport filt (input cfg, mode, frame_num, pkt_valid, pkt_fs, ecc_err,
                  cksum_err, len_err, short_line, output pass, drop);
endinterface

// [rtl/rpf_pkt_filter.sv]
/*
 * Per-port packet gate: frame-start wait and errored-packet filtering.
 * Assumes packet descriptors arrive on sys_clk from the port receiver.
 */
`timescale 1ns/1ps
module rpf_pkt_filter
    import rpf_pkg::*;
#(
    parameter int NUM_PORTS = NUM_PORTS_DEF
) (
    input wire logic   sys_clk,
    input wire logic   reset,
    input wire logic   ce,
    rpf_filt_if.filt   fif
);

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
        logic seen_fs_ff;
        logic seen_fs1_ff;
        logic pass_ff;
        logic drop_ff;

        // ----------------------------------------------------------------
        // Decode of this packet's fate
        // ----------------------------------------------------------------
        wire       raw     = is_raw(fif.mode[p]);
        wire       fs_now  = fif.pkt_fs[p];
        wire       fs1_now = fs_now && (fif.frame_num[p] == FRAME_NUM_ONE);
        // The start packet that ends the wait is itself accepted
        wire       blk_fs1 = fif.cfg[p][CFG_WAIT_FIRST]
                             && !(seen_fs1_ff || fs1_now);
        wire       blk_fs  = fif.cfg[p][CFG_WAIT_ANY]
                             && !(seen_fs_ff || fs_now);
        wire       blk     = !raw && (blk_fs1 || blk_fs);
        wire       bad_csi = (fif.cksum_err[p]
                              && !fif.cfg[p][CFG_PASS_CKSUM])
                          || (fif.ecc_err[p]
                              && !fif.cfg[p][CFG_PASS_HDR])
                          || (fif.len_err[p]
                              && !fif.cfg[p][CFG_BIT3]);
        wire       bad_raw = fif.short_line[p]
                             && fif.cfg[p][CFG_BIT3];
        wire       bad     = raw ? bad_raw : bad_csi;
        wire       go      = fif.pkt_valid[p] && !blk && !bad;

        // Start-seen flags persist until reset
        always_ff @(posedge sys_clk) begin
            if (reset) begin
                seen_fs_ff  <= 1'b0;
                seen_fs1_ff <= 1'b0;
                pass_ff     <= 1'b0;
                drop_ff     <= 1'b0;
            end else if (ce) begin
                seen_fs_ff  <= seen_fs_ff || (fif.pkt_valid[p] && fs_now);
                seen_fs1_ff <= seen_fs1_ff || (fif.pkt_valid[p] && fs1_now);
                pass_ff     <= go;
                drop_ff     <= fif.pkt_valid[p] && !go;
            end
        end

        assign fif.pass[p] = pass_ff;
        assign fif.drop[p] = drop_ff;

        // ----------------------------------------------------------------
        // Checks
        // ----------------------------------------------------------------
        chk_wait_any_blocks: assert property (
            ce && fif.pkt_valid[p] && !raw && fif.cfg[p][CFG_WAIT_ANY]
            && !seen_fs_ff && !fs_now |=> drop_ff && !pass_ff)
            else $error("packet passed before any frame start");
        chk_wait_first_blocks: assert property (
            ce && fif.pkt_valid[p] && !raw && fif.cfg[p][CFG_WAIT_FIRST]
            && !seen_fs1_ff && !fs1_now |=> drop_ff)
            else $error("packet passed before frame start one");
        chk_raw_ignores_wait: assert property (
            ce && fif.pkt_valid[p] && raw && !fif.short_line[p]
            |=> pass_ff)
            else $error("raw mode packet was gated");
        chk_hdr_err_drop: assert property (
            ce && fif.pkt_valid[p] && !raw && fif.ecc_err[p]
            && !fif.cfg[p][CFG_PASS_HDR] |=> !pass_ff)
            else $error("header errored packet forwarded");
        chk_cksum_pass: assert property (
            ce && fif.pkt_valid[p] && !raw && !blk && fif.cksum_err[p]
            && !fif.ecc_err[p] && !fif.len_err[p]
            |=> pass_ff == $past(fif.cfg[p][CFG_PASS_CKSUM]))
            else $error("checksum filter wrong");
        chk_raw_short_line: assert property (
            ce && fif.pkt_valid[p] && raw && fif.short_line[p]
            |=> drop_ff == $past(fif.cfg[p][CFG_BIT3]))
            else $error("truncated line handling wrong");
        cov_fs_unblocks: cover property (
            ce && fif.pkt_valid[p] && fs_now && !seen_fs_ff ##1 pass_ff);
        cov_len_drop: cover property (
            ce && fif.pkt_valid[p] && fif.len_err[p] ##1 drop_ff);
    end

endmodule

// [verification/rpf_cam_model.sv]
/*
 * Camera-side packet source that feeds the bank's packet inputs.
 * Assumes it shares sys_clk with the bank and sends one packet per call.
 */
`timescale 1ns/1ps
module rpf_cam_model
    import rpf_pkg::*;
#(
    parameter int NP = NUM_PORTS_DEF
) (
    input  wire logic                 sys_clk,
    output logic      [NP-1:0]        pkt_valid,
    output logic      [NP-1:0]        pkt_frame_start,
    output logic      [NP-1:0][15:0]  pkt_frame_num,
    output logic      [NP-1:0]        pkt_ecc_err,
    output logic      [NP-1:0]        pkt_cksum_err,
    output logic      [NP-1:0]        pkt_len_err,
    output logic      [NP-1:0]        pkt_short_line
);
    // Idle, no packet present
    initial begin
        pkt_valid = '0;
        pkt_frame_num = '0;
        {pkt_frame_start, pkt_ecc_err, pkt_cksum_err} = '0;
        {pkt_len_err, pkt_short_line} = '0;
    end

    // Fields flip once valid drops, so stale values are never trusted
    task automatic send(int p, logic [4:0] f, logic [15:0] n);
        @(posedge sys_clk);
        pkt_valid[p] <= 1'b1;
        {pkt_frame_start[p], pkt_ecc_err[p], pkt_cksum_err[p],
         pkt_len_err[p], pkt_short_line[p]} <= f;
        pkt_frame_num[p] <= n;
        @(posedge sys_clk);
        pkt_valid[p] <= 1'b0;
        {pkt_frame_start[p], pkt_ecc_err[p], pkt_cksum_err[p],
         pkt_len_err[p], pkt_short_line[p]} <= ~f;
        pkt_frame_num[p] <= ~n;
    endtask
endmodule

// [verification/rpf_port_regs_tb_top.sv]
/*
 * Self-checking bench for the receive-port register bank.
 * Assumes the bank's note: one-cycle strobes, answers one cycle later.
 */
`timescale 1ns/1ps
module rpf_port_regs_tb_top
    import rpf_pkg::*;
;
    logic              sys_clk = 1'b0;
    logic              reset = 1'b1;
    logic              reg_wr_en = 1'b0;
    logic              reg_rd_en = 1'b0;
    logic              ce = 1'b1;
    logic              i2c_addr_valid = 1'b0;
    logic              i2c_read = 1'b0;
    logic [7:0]        reg_addr = 8'h00;
    logic [7:0]        reg_wdata = 8'h00;
    logic [1:0]        strap_mode = 2'h1;
    logic [6:0]        i2c_addr = 7'h00;
    logic [7:0]        cfg_w;
    logic [4:0]        pf;
    logic [7:0]        reg_rdata_ff;
    logic              reg_rvalid_ff, remote_hit_ff, auto_ack_ff;
    logic [1:0]        remote_port_ff;
    logic [6:0]        remote_addr_ff, tid;
    logic [3:0]        pkt_valid, pkt_frame_start, pkt_ecc_err;
    logic [3:0]        pkt_cksum_err, pkt_len_err, pkt_short_line;
    logic [3:0]        pkt_pass_ff, pkt_drop_ff;
    logic [3:0][15:0]  pkt_frame_num;
    int                n_fail = 0;
    int                checks_done = 0;
    int                seed = 32'h6692;

    // 250 MHz system clock
    always #2 sys_clk = ~sys_clk;

    // Clock enable drops once to show that a write is frozen out
    rpf_port_regs #(.NUM_PORTS(4)) u_dut (.sys_clk, .reset, .ce,
        .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wdata, .reg_rdata_ff,
        .reg_rvalid_ff, .strap_mode, .i2c_addr_valid, .i2c_addr,
        .i2c_read, .remote_hit_ff, .remote_port_ff, .remote_addr_ff,
        .auto_ack_ff, .pkt_valid, .pkt_frame_start, .pkt_frame_num,
        .pkt_ecc_err, .pkt_cksum_err, .pkt_len_err, .pkt_short_line,
        .pkt_pass_ff, .pkt_drop_ff);
    rpf_cam_model u_cam (.sys_clk, .pkt_valid, .pkt_frame_start,
        .pkt_frame_num, .pkt_ecc_err, .pkt_cksum_err, .pkt_len_err,
        .pkt_short_line);

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
        checks_done++;
        if (g !== e) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(posedge sys_clk);
        reg_wr_en <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr_en <= 1'b0;
    endtask
    // Read answers on the edge that takes the strobe, one cycle after it is raised
    task automatic rdc(logic [7:0] a, logic [7:0] e);
        @(posedge sys_clk);
        reg_rd_en <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd_en <= 1'b0;
        #1;
        chk("rvalid", 8'h01, {7'h00, reg_rvalid_ff});
        chk("rdata", e, reg_rdata_ff);
    endtask
    task automatic ic(logic [6:0] a, logic r);
        @(posedge sys_clk);
        i2c_addr_valid <= 1'b1;
        i2c_addr <= a;
        i2c_read <= r;
        @(posedge sys_clk);
        i2c_addr_valid <= 1'b0;
        #1;
    endtask
    // One packet; exactly one of pass or drop must pulse
    task automatic pk(int p, logic [4:0] f, logic [15:0] n, logic e);
        u_cam.send(p, f, n);
        #1;
        chk("pass", {7'h00, e}, {7'h00, pkt_pass_ff[p]});
        chk("drop", {7'h00, !e}, {7'h00, pkt_drop_ff[p]});
    endtask
    // Expected fate of a packet once every frame-start wait is off
    function automatic logic exp_fwd(logic [7:0] c, logic [4:0] f);
        if (c[1:0] != MODE_CSI)
            return !(f[0] && c[CFG_BIT3]);
        return !((f[3] && !c[CFG_PASS_HDR]) || (f[2] && !c[CFG_PASS_CKSUM])
                 || (f[1] && !c[CFG_BIT3]));
    endfunction
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (6) @(posedge sys_clk);
        reset <= 1'b0;
        repeat (10) @(posedge sys_clk);
        rdc(ADDR_CFG, 8'h79);
        rdc(ADDR_ALIAS, 8'h00);
        rdc(8'h7F, 8'h00);
        tid = 7'($random(seed));
        wr(ADDR_PORT_SEL, 8'h01);
        wr(ADDR_TID, {1'b0, tid});
        wr(ADDR_ALIAS, 8'hA5);
        wr(ADDR_PORT_SEL, 8'h00);
        rdc(ADDR_ALIAS, 8'h00);
        ic(7'h52, 1'b0);
        chk("hit", 8'h01, {7'h00, remote_hit_ff});
        chk("port", 8'h01, {6'h00, remote_port_ff});
        chk("remap", {1'b0, tid}, {1'b0, remote_addr_ff});
        chk("ack", 8'h01, {7'h00, auto_ack_ff});
        ic(7'h52, 1'b1);
        chk("ack", 8'h00, {7'h00, auto_ack_ff});
        ic(7'h00, 1'b0);
        chk("hit", 8'h00, {7'h00, remote_hit_ff});
        // Port 0 gets its own alias and target id
        wr(ADDR_TID, 8'h2D);
        wr(ADDR_ALIAS, 8'h37);
        ic(7'h1B, 1'b0);
        chk("hit", 8'h01, {7'h00, remote_hit_ff});
        chk("port", 8'h00, {6'h00, remote_port_ff});
        chk("remap", 8'h2D, {1'b0, remote_addr_ff});
        chk("ack", 8'h01, {7'h00, auto_ack_ff});
        // Port 0 in CSI-2 mode with both waits and no forwarding
        wr(ADDR_CFG, 8'hC0);
        pk(0, 5'b00000, 16'h0001, 1'b0);
        pk(0, 5'b10000, 16'h0002, 1'b0);
        pk(0, 5'b10000, 16'h0001, 1'b1);
        pk(0, 5'b01000, 16'h0000, 1'b0);
        pk(0, 5'b00100, 16'h0000, 1'b0);
        pk(0, 5'b00010, 16'h0000, 1'b0);
        wr(ADDR_CFG, 8'h3C);
        rdc(ADDR_CFG, 8'h38);
        // Random filter bits and error flags across randomly drawn input modes
        for (int i = 0; i < 12; i++) begin
            cfg_w = {2'b00, 3'($random(seed)), 1'b0, 2'($random(seed))};
            pf = 5'($random(seed)) & 5'b01111;
            wr(ADDR_CFG, cfg_w);
            rdc(ADDR_CFG, cfg_w);
            pk(0, pf, 16'h0, exp_fwd(cfg_w, pf));
        end
        wr(ADDR_CFG, 8'h09);
        pk(0, 5'b00001, 16'h0000, 1'b0);
        pk(0, 5'b00100, 16'h0000, 1'b1);
        wr(ADDR_CFG, 8'h01);
        pk(0, 5'b00001, 16'h0000, 1'b1);
        // Port 1 keeps its own wait state
        wr(ADDR_PORT_SEL, 8'h01);
        rdc(ADDR_ALIAS, 8'hA5);
        wr(ADDR_CFG, 8'h40);
        pk(1, 5'b00000, 16'h0000, 1'b0);
        pk(1, 5'b10000, 16'h0005, 1'b1);
        wr(ADDR_CFG, 8'hC1);
        rdc(ADDR_CFG, 8'hC1);
        pk(1, 5'b00000, 16'h0000, 1'b1);
        // A write while the clock enable is low must not land
        @(posedge sys_clk);
        ce <= 1'b0;
        wr(ADDR_ALIAS, 8'h3C);
        ce <= 1'b1;
        rdc(ADDR_ALIAS, 8'hA5);
        // Mid-run reset clears the start-seen flags and reloads the strap
        @(posedge sys_clk);
        reset <= 1'b1;
        repeat (2) @(posedge sys_clk);
        reset <= 1'b0;
        repeat (6) @(posedge sys_clk);
        rdc(ADDR_CFG, 8'h79);
        wr(ADDR_CFG, 8'h40);
        pk(0, 5'b00000, 16'h0000, 1'b0);
        summarize();
    end

    // Watchdog at 5000 cycles, far beyond the under 200 cycles the run needs
    initial begin
        #20000;
        n_fail++;
        summarize();
    end
endmodule
